// *** hpbp_pkg.sv ***
// hpbp_pkg: constants shared by the host-side parallel bus controller
// assumes: single clock domain, synchronous pin inputs
package hpbp_pkg;
   // controller register offsets (word index on the local command port)
   localparam logic [3:0] CMD_OFS    = 4'h0;
   localparam logic [3:0] ADDR_OFS   = 4'h1;
   localparam logic [3:0] WDATA_OFS  = 4'h2;
   localparam logic [3:0] RDATA_OFS  = 4'h3;
   localparam logic [3:0] CFG_OFS    = 4'h4;
   localparam logic [3:0] STAT_OFS   = 4'h5;
   localparam logic [3:0] MASK_OFS   = 4'h6;
   // command register fields
   localparam int CMD_GO_BIT   = 0;
   localparam int CMD_READ_BIT = 1;
   // configuration register fields
   localparam int CFG_MUX_BIT  = 0;
   localparam int CFG_WIDE_BIT = 1;
   localparam int CFG_SEP_BIT  = 2;
   localparam int CFG_IRQPOL_BIT = 3;
   localparam logic [3:0] CFG_RST = 4'h4;
   // status / mask bits
   localparam int ST_DONE_BIT = 0;
   localparam int ST_IRQ_BIT  = 1;
   localparam logic [1:0] MASK_RST = 2'h0;
   // bus phase timing in ns and derived cycle counts at 250 MHz
   localparam int CLK_PERIOD_NS = 4;
   localparam int ALE_NS   = 20;
   localparam int STRB_NS  = 60;
   localparam int HOLD_NS  = 20;
   localparam int ALE_CYC  = (ALE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STRB_CYC = (STRB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // bus sequencer states, gray along idle-addr-strobe-hold
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ADDR = 2'b01,
      ST_STRB = 2'b11,
      ST_HOLD = 2'b10
   } hpbp_state_type;
endpackage

// *** hpbp_timer.sv ***
// hpbp_timer: loadable down counter marking the end of a bus phase
// assumes: load comes from the sequencer and enable from clk_en, both in the same clock domain
`timescale 1ns/1ps
`default_nettype none
module hpbp_timer #(
   parameter int WIDTH = 5
) (
   input  wire logic             clock,    // system clock
   input  wire logic             reset_n,  // async reset, active low
   input  wire logic             enable,   // clock enable
   input  wire logic             load,     // load a new count
   input  wire logic [WIDTH-1:0] count,    // cycles in the phase, minus one
   output logic                  expired   // phase over
);
   logic [WIDTH-1:0] cnt_r;

   // count down to zero, then hold
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r <= '0;
      end else if (enable) begin
         if (load) begin
            cnt_r <= count;
         end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end

   // expiry ignores load: the sequencer loads on expiry, so a load term would loop
   assign expired = (cnt_r == '0);
endmodule
`default_nettype wire

// *** hpbp_host.sv ***
// hpbp_host: host controller that drives the switch's parallel register port
// assumes: device pins sampled synchronously; pads resolve the *_oe_n enables
// Behaviour
// - chip select low during every access
// - separate mode: read or write strobe
// - strobe mode: write data held during strobe
// - direction line marks read or write
// - address valid before ALE falls
`timescale 1ns/1ps
`default_nettype none
module hpbp_host #(
   parameter int AW = 5,
   parameter int DW = 16
) (
   input  wire logic          clock,          // 250 MHz clock
   input  wire logic          reset_n,        // async reset, active low
   input  wire logic          clk_en,         // freezes all state when low
   input  wire logic [3:0]    reg_addr,       // local register index
   input  wire logic [31:0]   reg_wdata,      // local write data
   input  wire logic          reg_wr,         // local write strobe
   input  wire logic          reg_rd,         // local read strobe
   output logic [31:0]        reg_rdata,      // read data, cycle after reg_rd
   output logic               irq,            // controller interrupt, level
   output logic               dev_cs_n,       // chip select to device
   output logic               dev_rd_n,       // read strobe or transfer_strobe
   output logic               dev_wr_n,       // write strobe or direction
   output logic               dev_ale,        // address latch enable
   output logic               dev_reset_n,    // system reset to device
   output logic               bus_width_select, // 0 = 8 bit, 1 = 16 bit
   output logic [AW-1:0]      dev_addr,       // separate address bus
   output logic [DW-1:0]      dev_d_out,      // data bus drive value
   output logic               dev_d_oe_n,     // data drive enable, low drives
   input  wire logic [DW-1:0] dev_d_in,       // data bus sampled
   input  wire logic          interrupt_request_out // device interrupt pin level
);
   hpbp_pkg::hpbp_state_type state_r;
   logic          mux_r, wide_r, sep_r, irqpol_r, read_r, done_r;
   logic [AW-1:0] addr_r;
   logic [DW-1:0] wdata_r, rdata_r;
   logic [1:0]    stat_r, mask_r;
   logic          go, phase_end, tload;
   logic [4:0]    tcount;
   logic          dev_irq, irq_d_r;

   assign go = reg_wr && (reg_addr == hpbp_pkg::CMD_OFS) && reg_wdata[hpbp_pkg::CMD_GO_BIT];

   hpbp_timer #(.WIDTH(5)) u_timer (
      .clock   (clock),
      .reset_n (reset_n),
      .enable  (clk_en),
      .load    (tload),
      .count   (tcount),
      .expired (phase_end)
   );

   // configuration and transfer operands
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         {irqpol_r, sep_r, wide_r, mux_r} <= hpbp_pkg::CFG_RST;
         addr_r  <= '0;
         wdata_r <= '0;
         read_r  <= 1'b0;
         mask_r  <= hpbp_pkg::MASK_RST;
      end else if (clk_en && reg_wr) begin
         case (reg_addr)
            hpbp_pkg::CFG_OFS: begin
               // convention bits only change while the bus is idle
               if (state_r == hpbp_pkg::ST_IDLE) begin
                  {irqpol_r, sep_r, wide_r, mux_r} <= reg_wdata[3:0];
               end
            end
            hpbp_pkg::ADDR_OFS:  addr_r  <= reg_wdata[AW-1:0];
            hpbp_pkg::WDATA_OFS: wdata_r <= reg_wdata[DW-1:0];
            hpbp_pkg::MASK_OFS:  mask_r  <= reg_wdata[1:0];
            hpbp_pkg::CMD_OFS: begin
               if (state_r == hpbp_pkg::ST_IDLE) begin
                  read_r <= reg_wdata[hpbp_pkg::CMD_READ_BIT];
               end
            end
            default: ;
         endcase
      end
   end

   // bus sequencer: addr phase (ALE pulse in mux mode), strobe, hold
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= hpbp_pkg::ST_IDLE;
      end else if (clk_en) begin
         case (state_r)
            hpbp_pkg::ST_IDLE: if (go) state_r <= hpbp_pkg::ST_ADDR;
            hpbp_pkg::ST_ADDR: if (phase_end) state_r <= hpbp_pkg::ST_STRB;
            hpbp_pkg::ST_STRB: if (phase_end) state_r <= hpbp_pkg::ST_HOLD;
            hpbp_pkg::ST_HOLD: if (phase_end) state_r <= hpbp_pkg::ST_IDLE;
            default: state_r <= hpbp_pkg::ST_IDLE;
         endcase
      end
   end

   // phase lengths loaded on each entry; the timer spends one cycle at zero,
   // so each phase loads one less than its length in cycles
   always_comb begin
      tload  = 1'b0;
      tcount = '0;
      case (state_r)
         hpbp_pkg::ST_IDLE: begin
            tload  = go;
            tcount = 5'(hpbp_pkg::ALE_CYC - 1);
         end
         hpbp_pkg::ST_ADDR: begin
            tload  = phase_end;
            tcount = 5'(hpbp_pkg::STRB_CYC - 1);
         end
         hpbp_pkg::ST_STRB: begin
            tload  = phase_end;
            tcount = 5'(hpbp_pkg::HOLD_CYC - 1);
         end
         default: ;
      endcase
   end

   // capture read data at the end of the strobe, while device drives it
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rdata_r <= '0;
      end else if (clk_en && state_r == hpbp_pkg::ST_STRB && phase_end && read_r) begin
         // upper byte only meaningful in 16-bit mode
         rdata_r <= wide_r ? dev_d_in : {{(DW-8){1'b0}}, dev_d_in[7:0]};
      end
   end

   // pin outputs, registered so strobes are glitch free
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         dev_cs_n   <= 1'b1;
         dev_rd_n   <= 1'b1;
         dev_wr_n   <= 1'b1;
         dev_ale    <= 1'b0;
         dev_addr   <= '0;
         dev_d_out  <= '0;
         dev_d_oe_n <= 1'b1;
         bus_width_select <= 1'b0;
      end else if (clk_en) begin
         bus_width_select <= wide_r;
         dev_cs_n <= (state_r == hpbp_pkg::ST_IDLE);
         dev_addr <= addr_r;
         // mux: ALE pulses in addr phase; else static level picks convention
         if (mux_r) begin
            dev_ale <= (state_r == hpbp_pkg::ST_ADDR);
         end else begin
            dev_ale <= sep_r;
         end
         if (sep_r) begin
            dev_rd_n <= !(state_r == hpbp_pkg::ST_STRB && read_r);
            dev_wr_n <= !(state_r == hpbp_pkg::ST_STRB && !read_r);
         end else begin
            dev_rd_n <= (state_r != hpbp_pkg::ST_STRB);                   // transfer_strobe
            dev_wr_n <= read_r;
         end
         // drive address in addr phase when muxed; write data through hold
         if (mux_r && state_r == hpbp_pkg::ST_ADDR) begin
            dev_d_out  <= {{(DW-AW){1'b0}}, addr_r};
            dev_d_oe_n <= 1'b0;
         end else if (!read_r && state_r != hpbp_pkg::ST_IDLE) begin
            dev_d_out  <= wdata_r;
            dev_d_oe_n <= 1'b0;
         end else begin
            // release the bus so the device may drive it on reads
            dev_d_oe_n <= 1'b1;
         end
      end
   end

   // device reset follows controller reset; the device stays off the bus
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         dev_reset_n <= 1'b0;
      end else if (clk_en) begin
         dev_reset_n <= 1'b1;
      end
   end

   // device interrupt level per configured polarity; open-drain reads low
   assign dev_irq = irqpol_r ? interrupt_request_out : !interrupt_request_out;

   // sticky status, set wins over write-one-to-clear
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         stat_r  <= '0;
         irq_d_r <= 1'b0;
         done_r  <= 1'b0;
      end else if (clk_en) begin
         irq_d_r <= dev_irq && dev_reset_n;
         done_r  <= (state_r == hpbp_pkg::ST_HOLD) && phase_end;
         for (int i = 0; i < 2; i++) begin
            if (reg_wr && reg_addr == hpbp_pkg::STAT_OFS && reg_wdata[i]) begin
               stat_r[i] <= 1'b0;
            end
         end
         if (done_r) stat_r[hpbp_pkg::ST_DONE_BIT] <= 1'b1;
         if (dev_irq && dev_reset_n && !irq_d_r) stat_r[hpbp_pkg::ST_IRQ_BIT] <= 1'b1;
      end
   end

   assign irq = |(stat_r & mask_r);

   // local read port, data one cycle after the strobe
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= '0;
      end else if (clk_en) begin
         reg_rdata <= '0;
         if (reg_rd) begin
            case (reg_addr)
               hpbp_pkg::CMD_OFS:   reg_rdata <= {30'h0, read_r, state_r != hpbp_pkg::ST_IDLE};
               hpbp_pkg::ADDR_OFS:  reg_rdata <= 32'(addr_r);
               hpbp_pkg::WDATA_OFS: reg_rdata <= 32'(wdata_r);
               hpbp_pkg::RDATA_OFS: reg_rdata <= 32'(rdata_r);
               hpbp_pkg::CFG_OFS:   reg_rdata <= {28'h0, irqpol_r, sep_r, wide_r, mux_r};
               hpbp_pkg::STAT_OFS:  reg_rdata <= {30'h0, stat_r};
               hpbp_pkg::MASK_OFS:  reg_rdata <= {30'h0, mask_r};
               default:             reg_rdata <= '0;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// *** hpbp_host_sva.sv ***
// hpbp_host_sva: pin-level checks on the host controller
// assumes: bound into hpbp_host, one clock domain
`timescale 1ns/1ps
`default_nettype none
module hpbp_host_chk #(
   parameter int AW = 5,
   parameter int DW = 16
) (
   input wire logic          clock,       // clock
   input wire logic          reset_n,     // reset, active low
   input wire logic          dev_cs_n,    // chip select
   input wire logic          dev_rd_n,    // read or transfer strobe
   input wire logic          dev_wr_n,    // write strobe or direction
   input wire logic          dev_ale,     // address latch enable
   input wire logic          dev_reset_n, // device reset
   input wire logic [AW-1:0] dev_addr,    // address bus
   input wire logic [DW-1:0] dev_d_out,   // data drive value
   input wire logic          dev_d_oe_n   // data enable, low drives
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   // device reset trails the controller's own by one edge
   AST_RST: assert property ($rose(reset_n) |-> !dev_reset_n ##1 dev_reset_n)
      else $error("device reset release wrong");
   AST_STRB_CS: assert property (!dev_rd_n |-> !dev_cs_n)
      else $error("strobe without chip select");
   AST_OE_CS: assert property (dev_cs_n |-> dev_d_oe_n)
      else $error("data driven while deselected");
   AST_RD_NODRV: assert property (!dev_rd_n && dev_wr_n |-> dev_d_oe_n)
      else $error("data driven during read");
   // strobe stands exactly fifteen cycles
   AST_STRB_LEN: assert property ($fell(dev_rd_n) |-> ##14 !dev_rd_n ##1 dev_rd_n)
      else $error("strobe length wrong");
   AST_WR_HOLD: assert property (!dev_wr_n && !dev_rd_n && !$past(dev_rd_n) |->
      $stable(dev_d_out) && !dev_d_oe_n)
      else $error("write data moved under strobe");
   AST_DIR: assert property (!dev_rd_n && !$past(dev_rd_n) |-> $stable(dev_wr_n))
      else $error("direction moved under strobe");
   // address must sit on the bus as the latch opens, and the latch stays open five cycles
   AST_ALE: assert property ($rose(dev_ale) && !dev_cs_n |->
      !dev_d_oe_n && dev_d_out[AW-1:0] == dev_addr ##1 dev_ale[*4] ##1 !dev_ale)
      else $error("address phase wrong");
   cover property ($fell(dev_rd_n) && dev_wr_n);
   cover property ($fell(dev_rd_n) && !dev_wr_n);
   cover property ($rose(dev_ale) && !dev_cs_n);
endmodule
bind hpbp_host hpbp_host_chk #(.AW(AW), .DW(DW)) u_chk (.clock, .reset_n, .dev_cs_n, .dev_rd_n,
   .dev_wr_n, .dev_ale, .dev_reset_n, .dev_addr, .dev_d_out, .dev_d_oe_n);
`default_nettype wire

// *** hpbp_dev_model.sv ***
// hpbp_dev_model: register device on the far side of the parallel bus
// assumes: pins change just after clock edges; bench sets the strap inputs
`timescale 1ns/1ps
`default_nettype none
module hpbp_dev_model (
   input wire logic        clock,  // sample clock
   input wire logic        cs_n,   // chip select
   input wire logic        rd_n,   // read or transfer strobe
   input wire logic        wr_n,   // write strobe or direction
   input wire logic        ale,    // address latch enable
   input wire logic        rst_n,  // device reset
   input wire logic        wide,   // width select
   input wire logic        mux,    // address carried on data bus
   input wire logic [4:0]  a_pin,  // address pins
   input wire logic [15:0] d_pin,  // host data drive
   input wire logic        d_oe_n, // host drives when low
   input wire logic [3:0]  lat,    // strobe cycles before data valid
   input wire logic        pend,   // interrupt pending
   input wire logic        od,     // open-drain interrupt
   input wire logic        pol,    // push-pull active level
   output logic [15:0]     d_bus,  // resolved data bus
   output logic            irq_pin // interrupt wire, pulled up
);
   logic [15:0] mem [32];
   logic [15:0] last, d_q;
   logic [4:0]  a_lat, a;
   logic [3:0]  n;
   logic        sp, rd, wr, wr_q;
   // convention follows how ale idles; muxed parts use strobe and direction
   assign sp = !mux && ale;
   assign a  = mux ? a_lat : a_pin;
   assign rd = !cs_n && !rd_n && (sp || wr_n);
   assign wr = !cs_n && (sp ? !wr_n : !rd_n && !wr_n);
   // a slow answer shows a changing pattern, never stale data
   assign d_bus = !d_oe_n ? d_pin : rd && n >= lat ?
      (wide ? mem[a] : {~last[15:8], mem[a][7:0]}) : ~last;
   // pulled up: open drain only pulls low, reset leaves it floating
   assign irq_pin = !rst_n || (od ? !pend : pend == pol);
   always @(posedge clock) begin
      last <= d_bus;
      d_q  <= d_pin;
      wr_q <= wr;
      n    <= rd ? n + {3'h0, n != 4'hf} : 4'h0;
      if (ale) a_lat <= d_pin[4:0];
      if (!rst_n) mem <= '{default: 16'h0000};
      else if (wr_q && !wr && wide) mem[a] <= d_q;
      else if (wr_q && !wr) mem[a][7:0] <= d_q[7:0];
   end
endmodule
`default_nettype wire

// *** test_hpbp_host.sv ***
// test_hpbp_host: random and corner transfers through the host controller
// assumes: design, checker and device model compiled before this file
`timescale 1ns/1ps
`default_nettype none
module test_hpbp_host;
   logic        clock = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, mux = 0, pend = 0, od = 0, pol = 0;
   logic        clk_en = 1;
   logic [3:0]  reg_addr = 4'h0, lat = 4'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, v, cfg = 32'h4;
   logic        irq, dev_cs_n, dev_rd_n, dev_wr_n, dev_ale, dev_reset_n, bus_width_select;
   logic        dev_d_oe_n, interrupt_request_out;
   logic [4:0]  dev_addr;
   logic [15:0] dev_d_out, dev_d_in, mirror [32];
   int          failures = 0, compares = 0, cyc = 0, seed = 32'h7b907772;
   hpbp_host dut (.clock, .reset_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .irq, .dev_cs_n, .dev_rd_n, .dev_wr_n, .dev_ale, .dev_reset_n, .bus_width_select,
      .dev_addr, .dev_d_out, .dev_d_oe_n, .dev_d_in, .interrupt_request_out);
   hpbp_dev_model u_dev (.clock, .cs_n(dev_cs_n), .rd_n(dev_rd_n), .wr_n(dev_wr_n), .ale(dev_ale),
      .rst_n(dev_reset_n), .wide(bus_width_select), .mux, .a_pin(dev_addr), .d_pin(dev_d_out),
      .d_oe_n(dev_d_oe_n), .lat, .pend, .od, .pol, .d_bus(dev_d_in), .irq_pin(interrupt_request_out));
   initial forever #2 clock = ~clock;
   task automatic print_verdict;
      if (failures == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // a hang counts as a mismatch
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         print_verdict();
      end
   end
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one local cycle; read data lands in v the cycle after the strobe
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= w;
      reg_rd    <= !w;
      @(posedge clock);
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b0;
      #1 v = reg_rdata;
   endtask
   function automatic logic [31:0] rexp(input logic w, input logic [15:0] m);
      return w ? {16'h0, m} : {24'h0, m[7:0]};
   endfunction
   // device transfer; the config write lands while busy and must be ignored
   task automatic xfer(input logic rd, input logic [4:0] a, input logic [15:0] d);
      int k;
      bus(1, hpbp_pkg::ADDR_OFS, {27'h0, a});
      bus(1, hpbp_pkg::WDATA_OFS, {16'h0, d});
      bus(1, hpbp_pkg::CMD_OFS, {30'h0, rd, 1'b1});
      bus(1, hpbp_pkg::CFG_OFS, cfg ^ 32'h2);
      v = 0;
      for (k = 0; k < 40 && !v[0]; k++) bus(0, hpbp_pkg::STAT_OFS, 0);
      cmp("done", 1, v & 1);
      bus(1, hpbp_pkg::STAT_OFS, 1);
      bus(0, hpbp_pkg::RDATA_OFS, 0);
      if (!rd && cfg[1]) mirror[a] = d;
      else if (!rd) mirror[a][7:0] = d[7:0];
   endtask
   initial begin
      logic [4:0] a [2];
      int m, i;
      for (i = 0; i < 32; i++) mirror[i] = 16'h0000;
      repeat (10) @(posedge clock);
      cmp("oe_n", 1, {31'h0, dev_d_oe_n});
      cmp("irq pin", 1, {31'h0, interrupt_request_out});
      reset_n <= 1'b1;
      bus(0, hpbp_pkg::CFG_OFS, 0);
      cmp("cfg", {28'h0, hpbp_pkg::CFG_RST}, v);
      bus(0, hpbp_pkg::MASK_OFS, 0);
      cmp("mask", {30'h0, hpbp_pkg::MASK_RST}, v);
      // a write while the enable is low must leave the register untouched
      clk_en <= 1'b0;
      bus(1, hpbp_pkg::MASK_OFS, 3);
      clk_en <= 1'b1;
      bus(0, hpbp_pkg::MASK_OFS, 0);
      cmp("frozen mask", {30'h0, hpbp_pkg::MASK_RST}, v);
      bus(0, 4'hf, 0);
      cmp("unmapped", 0, v);
      // separate, strobe and muxed conventions at both widths
      for (m = 0; m < 6; m++) begin
         cfg = {29'h0, m < 2, m[0], m > 3};
         mux <= m > 3;
         bus(1, hpbp_pkg::CFG_OFS, cfg);
         for (i = 0; i < 4; i++) begin
            if (i < 2) a[i] = i[0] ? {5{m[1]}} : 5'($random(seed));
            lat <= 4'($random(seed)) & 4'h7;
            xfer(i > 1, a[i & 1], 16'($random(seed)));
            if (i > 1) cmp("rdata", rexp(cfg[1], mirror[a[i & 1]]), v);
         end
         cmp("width", {31'h0, cfg[1]}, {31'h0, bus_width_select});
         cmp("ale idle", {31'h0, cfg[2]}, {31'h0, dev_ale});
      end
      // push-pull active high unmasked, then open drain masked
      for (i = 0; i < 2; i++) begin
         bus(1, hpbp_pkg::CFG_OFS, {28'h0, !i[0], 3'h4});
         od  <= i[0];
         pol <= !i[0];
         repeat (4) @(posedge clock);
         bus(1, hpbp_pkg::STAT_OFS, 3);
         bus(1, hpbp_pkg::MASK_OFS, {30'h0, !i[0], 1'b0});
         pend <= 1'b1;
         repeat (6) @(posedge clock);
         bus(0, hpbp_pkg::STAT_OFS, 0);
         cmp("irq status", 2, v);
         cmp("irq", {31'h0, !i[0]}, {31'h0, irq});
         pend <= 1'b0;
         bus(1, hpbp_pkg::STAT_OFS, 2);
         bus(0, hpbp_pkg::STAT_OFS, 0);
         cmp("cleared", 0, {v[31:1], irq});
      end
      print_verdict();
   end
endmodule
`default_nettype wire
